// *** afsp_pkg.sv ***
// afsp_pkg: register map, field positions, reset values and timing
// assumes a 40 MHz system clock and 32-bit classic wishbone access
package afsp_pkg;
   localparam int unsigned AFSP_CLK_HZ = 40000000;
   localparam int unsigned AFSP_SAMPLE_BITS = 16;
   // register byte offsets
   localparam logic [3:0] AFSP_REG_CTRL = 4'h0;
   localparam logic [3:0] AFSP_REG_STATUS = 4'h4;
   localparam logic [3:0] AFSP_REG_TXDATA = 4'h8;
   localparam logic [3:0] AFSP_REG_RXDATA = 4'hc;
   // control fields
   localparam int AFSP_CTRL_SLAVE_BIT = 0;
   localparam int AFSP_CTRL_LONG_BIT = 1;
   localparam int AFSP_CTRL_RATE_LSB = 4;
   localparam int AFSP_CTRL_EN_BIT = 8;
   // rate select codes: bit clock in kHz
   localparam logic [2:0] AFSP_RATE_256 = 3'h0;
   localparam logic [2:0] AFSP_RATE_512 = 3'h1;
   localparam logic [2:0] AFSP_RATE_1024 = 3'h2;
   localparam logic [2:0] AFSP_RATE_2048 = 3'h3;
   localparam logic [2:0] AFSP_RATE_4096 = 3'h4;
   localparam int unsigned AFSP_BCLK_2048_KHZ = 2048;
   // reset: master, short frame, 2048 kHz, enabled
   localparam logic [8:0] AFSP_CTRL_RESET = 9'h130;
   // status bits
   localparam int AFSP_ST_RXVALID_BIT = 0;
   localparam int AFSP_ST_TXEMPTY_BIT = 1;
   // bit clocks per frame for each rate (8 kHz, 4096 at 16 kHz)
   localparam logic [8:0] AFSP_BITS_256 = 9'd32;
   // half period of bit clock in system clocks: 40000/(2*kHz), floor
   function automatic logic [7:0] afsp_half(input logic [2:0] rate);
      int unsigned khz;
      khz = 256 << rate;
      afsp_half = 8'((AFSP_CLK_HZ / 1000) / (2 * khz));
   endfunction
   // bit clocks per frame: rate/8k, but 4096 kHz runs 16 kHz frames
   function automatic logic [8:0] afsp_frame_bits(input logic [2:0] rate);
      if (rate == AFSP_RATE_4096)
         afsp_frame_bits = 9'd256;
      else
         afsp_frame_bits = AFSP_BITS_256 << rate;
   endfunction
endpackage

// *** afsp_port.sv ***
// afsp_port: audio frame serial port with classic wishbone registers
// assumes codec pins are asynchronous and pass a two-stage synchroniser
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module afsp_port
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [3:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   input wire logic i_wb_we,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_bclk,
   output logic o_bclk,
   output logic o_bclk_oe,
   input wire logic i_fsync,
   output logic o_fsync,
   output logic o_fsync_oe,
   input wire logic i_sdin,
   output logic o_sdout
);
   import afsp_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [8:0] ctrl;
   logic [15:0] tx_hold;
   logic tx_empty;
   logic [15:0] rx_hold;
   logic rx_valid;
   logic wb_hit;
   logic tx_take;
   logic rx_done;
   logic [15:0] rx_word;
   logic is_master;
   logic long_mode;
   logic [2:0] rate;
   logic wr_ctrl;
   logic wr_tx;
   logic rd_rx;

   assign long_mode = ctrl[AFSP_CTRL_LONG_BIT];
   // long frame can never be slave
   assign is_master = long_mode | ~ctrl[AFSP_CTRL_SLAVE_BIT];
   assign rate = ctrl[AFSP_CTRL_RATE_LSB +: 3];
   // ack masks the request so a held strobe is taken only once
   assign wb_hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   // register strobes, each decoded once and used by one process
   assign wr_ctrl = wb_hit & i_wb_we & (i_wb_adr == AFSP_REG_CTRL);
   assign wr_tx = wb_hit & i_wb_we & (i_wb_adr == AFSP_REG_TXDATA) &
      (i_wb_sel[1:0] != 2'h0);
   assign rd_rx = wb_hit & ~i_wb_we & (i_wb_adr == AFSP_REG_RXDATA);

   // one-wait-state answer; ack drops the cycle after
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         o_wb_ack <= 1'b0;
      else
         o_wb_ack <= wb_hit;
   end

   // control register, writable in low bytes
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         ctrl <= AFSP_CTRL_RESET;
      else if (wr_ctrl)
      begin
         if (i_wb_sel[0])
            ctrl[7:0] <= i_wb_dat[7:0];
         if (i_wb_sel[1])
            ctrl[8] <= i_wb_dat[8];
      end
   end

   // transmit holding word; frame start takes it, write refills
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         tx_hold <= 16'h0000;
         tx_empty <= 1'b1;
      end
      else if (wr_tx)
      begin
         if (i_wb_sel[0])
            tx_hold[7:0] <= i_wb_dat[7:0];
         if (i_wb_sel[1])
            tx_hold[15:8] <= i_wb_dat[15:8];
         tx_empty <= 1'b0;
      end
      else if (tx_take)
         tx_empty <= 1'b1;
   end

   // receive holding word; a new sample wins over the read clear
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         rx_hold <= 16'h0000;
         rx_valid <= 1'b0;
      end
      else if (rx_done)
      begin
         rx_hold <= rx_word;
         rx_valid <= 1'b1;
      end
      else if (rd_rx)
         rx_valid <= 1'b0;
   end

   // read mux; unmapped addresses read zero and still ack
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         o_wb_dat <= 32'h0000_0000;
      else if (wb_hit && !i_wb_we)
      begin
         unique case (i_wb_adr)
            AFSP_REG_CTRL: o_wb_dat <= {23'h0, ctrl};
            AFSP_REG_STATUS: o_wb_dat <= {30'h0, tx_empty, rx_valid};
            AFSP_REG_TXDATA: o_wb_dat <= {16'h0, tx_hold};
            AFSP_REG_RXDATA: o_wb_dat <= {16'h0, rx_hold};
            default: o_wb_dat <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // master clock and sync generation
   logic [7:0] div_cnt;
   logic [8:0] bit_cnt;
   logic gen_bclk;
   logic gen_fsync;
   logic gen_rise;
   logic gen_fall;
   logic gen_tick;

   // terminal count; >= so a rate rise mid-period toggles at once
   // instead of running the counter round through 255
   assign gen_tick = div_cnt >= afsp_half(rate) - 8'h01;

   // half-period divider; runs free, the frame count wrap never resets it
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         div_cnt <= 8'h00;
         gen_bclk <= 1'b0;
      end
      else if (gen_tick)
      begin
         div_cnt <= 8'h00;
         gen_bclk <= ~gen_bclk;
      end
      else
         div_cnt <= div_cnt + 8'h01;
   end

   assign gen_rise = gen_tick & ~gen_bclk;
   assign gen_fall = gen_tick & gen_bclk;

   // bit counter on rising generated edge; sync shape per mode
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         bit_cnt <= 9'h000;
         gen_fsync <= 1'b0;
      end
      else if (gen_rise)
      begin
         if (bit_cnt >= afsp_frame_bits(rate) - 9'h001)
            bit_cnt <= 9'h000;
         else
            bit_cnt <= bit_cnt + 9'h001;
         // long: high for first half frame, 50 percent duty
         if (long_mode)
            gen_fsync <= (bit_cnt >= afsp_frame_bits(rate) - 9'h001) |
               (bit_cnt < (afsp_frame_bits(rate) >> 1) - 9'h001);
         // short: one bit-clock pulse before the msb
         else
            gen_fsync <= bit_cnt == afsp_frame_bits(rate) - 9'h002;
      end
   end

   // pin drivers; enables follow master role
   // bclk pin takes the next phase, so sdout moves with its rise
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_bclk <= 1'b0;
         o_fsync <= 1'b0;
         o_bclk_oe <= 1'b0;
         o_fsync_oe <= 1'b0;
      end
      else
      begin
         o_bclk <= gen_bclk ^ gen_tick;
         o_fsync <= gen_fsync;
         o_bclk_oe <= is_master;
         o_fsync_oe <= is_master;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; slave mode samples the pins
   // only the second stage is read; the first may be metastable
   logic [1:0] bclk_sy;
   logic [1:0] fs_sy;
   logic [1:0] din_sy;
   logic bclk_d;
   logic fs_d;

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         bclk_sy <= 2'h0;
         fs_sy <= 2'h0;
         din_sy <= 2'h0;
         bclk_d <= 1'b0;
         fs_d <= 1'b0;
      end
      else
      begin
         bclk_sy <= {bclk_sy[0], i_bclk};
         fs_sy <= {fs_sy[0], i_fsync};
         din_sy <= {din_sy[0], i_sdin};
         bclk_d <= bclk_sy[1];
         fs_d <= fs_sy[1];
      end
   end

   // unified edge view: generated in master, synchronised in slave
   logic e_rise;
   logic e_fall;
   logic fs_lvl;
   logic fs_prev;

   assign e_rise = is_master ? gen_rise : (bclk_sy[1] & ~bclk_d);
   assign e_fall = is_master ? gen_fall : (~bclk_sy[1] & bclk_d);
   assign fs_lvl = is_master ? gen_fsync : fs_sy[1];

   ////////////////////////////////////////////////////////////////////////
   // serial engine
   logic [15:0] tx_shift;
   logic [15:0] rx_shift;
   logic [4:0] tx_left;
   logic [4:0] rx_left;
   logic frame_go;

   // sync level sampled at falling edges; codec launches on rising
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         fs_prev <= 1'b0;
      else if (e_fall)
         fs_prev <= fs_lvl;
   end

   // short: sync seen high then low; long: low then high
   assign frame_go = e_fall & ctrl[AFSP_CTRL_EN_BIT] &
      (long_mode ? (fs_lvl & ~fs_prev) : (~fs_lvl & fs_prev));
   assign tx_take = frame_go;

   // transmit: load at frame start, msb launched at next rising edge
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         tx_shift <= 16'h0000;
         tx_left <= 5'h00;
         o_sdout <= 1'b0;
      end
      else if (frame_go)
      begin
         tx_shift <= tx_empty ? 16'h0000 : tx_hold;
         tx_left <= 5'd16;
      end
      else if (e_rise)
      begin
         if (tx_left != 5'h00)
         begin
            o_sdout <= tx_shift[15];
            tx_shift <= {tx_shift[14:0], 1'b0};
            tx_left <= tx_left - 5'h01;
         end
         else
            o_sdout <= 1'b0;
      end
   end

   // receive: falling edges after the frame start carry msb first
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         rx_shift <= 16'h0000;
         rx_left <= 5'h00;
      end
      else if (frame_go)
         rx_left <= 5'd16;
      else if (e_fall && rx_left != 5'h00)
      begin
         rx_shift <= {rx_shift[14:0], din_sy[1]};
         rx_left <= rx_left - 5'h01;
      end
   end

   // completion pulse once sixteenth bit lands
   logic rx_busy_d;
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         rx_busy_d <= 1'b0;
      else
         rx_busy_d <= rx_left != 5'h00;
   end
   assign rx_done = rx_busy_d & (rx_left == 5'h00);
   assign rx_word = rx_shift;
endmodule
`default_nettype wire

// *** afsp_port_asserts.sv ***
// afsp_port_asserts: port checks on afsp_port, bound below
// assumes one i_clk domain with async active-high i_reset
`timescale 1ns/1ps
`default_nettype none
module afsp_port_asserts
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic o_wb_ack,
   input wire logic o_bclk,
   input wire logic o_bclk_oe,
   input wire logic o_fsync,
   input wire logic o_fsync_oe,
   input wire logic o_sdout
);
   logic [7:0] quiet;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   // still time of the driven bit clock, so a dead divider shows
   always_ff @(posedge i_clk or posedge i_reset)
      if (i_reset)
         quiet <= 8'h0;
      else if (!o_bclk_oe || $changed(o_bclk))
         quiet <= 8'h0;
      else
         quiet <= quiet + 8'h1;
   ////////////////////////////////////////////////////////////
   // bus answer, pin ownership and master link timing
   property p_take;
      i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
   endproperty
   a_take: assert property (p_take) else $error("no ack");
   property p_ack1;
      o_wb_ack |=> !o_wb_ack;
   endproperty
   a_ack1: assert property (p_ack1) else $error("long ack");
   property p_own;
      o_bclk_oe == o_fsync_oe;
   endproperty
   a_own: assert property (p_own) else $error("oe split");
   property p_boot;
      $fell(i_reset) |-> ##[1:2] o_bclk_oe;
   endproperty
   a_boot: assert property (p_boot) else $error("no master");
   property p_launch;
      o_bclk_oe && $past(o_bclk_oe) && $changed(o_sdout) |-> o_bclk;
   endproperty
   a_launch: assert property (p_launch) else $error("sd edge");
   property p_sync;
      o_fsync_oe && $past(o_fsync_oe) && $changed(o_fsync) |-> o_bclk;
   endproperty
   a_sync: assert property (p_sync) else $error("fs edge");
   property p_half;
      o_bclk_oe && $changed(o_bclk) |=> $stable(o_bclk) [*3];
   endproperty
   a_half: assert property (p_half) else $error("fast clk");
   property p_alive;
      o_bclk_oe |-> quiet < 8'd100;
   endproperty
   a_alive: assert property (p_alive) else $error("clk stuck");
   c_ack: cover property (o_wb_ack);
   c_slave: cover property ($fell(o_bclk_oe));
   c_sync: cover property ($rose(o_fsync));
endmodule
bind afsp_port afsp_port_asserts u_chk (.*);
`default_nettype wire

// *** afsp_codec_model.sv ***
// afsp_codec_model: behavioural codec on the far side of the link
// assumes the bench resolves shared clock and sync pin levels
`timescale 1ns/1ps
`default_nettype none
module afsp_codec_model
(
   input wire logic i_bclk,
   input wire logic i_fsync,
   input wire logic i_sdout,
   input wire logic i_long,
   input wire logic i_go,
   input wire logic [15:0] i_tx,
   output logic o_bclk,
   output logic o_fsync,
   output logic o_sdin,
   output logic [15:0] o_rx,
   output logic [7:0] o_count
);
   logic fs_last = 1'b0;
   logic [15:0] sh;
   int rx_left = 0;
   int tx_left = 0;
   initial
      {o_bclk, o_fsync, o_sdin, o_count} = '0;
   ////////////////////////////////////////////////////////////
   // frame start and capture on the falling bit clock
   always @(negedge i_bclk)
   begin
      if (rx_left > 0)
      begin
         sh = {sh[14:0], i_sdout};
         rx_left--;
         if (rx_left == 0)
            o_count++;
         o_rx = sh;
      end
      else if (fs_last != i_fsync && i_fsync == i_long)
      begin
         rx_left = 16;
         tx_left = 16;
      end
      fs_last = i_fsync;
   end
   // launch on rising; idle bits toggle so no stale level lingers
   always @(posedge i_bclk)
      if (tx_left > 0)
      begin
         o_sdin = i_tx[tx_left - 1];
         tx_left--;
      end
      else
         o_sdin = ~o_sdin;
   // as clock master: one burst per frame, clock still between
   always @(posedge i_go)
   begin
      rx_left = 0;
      tx_left = 0;
      // start off the system clock edge, so no pin sample races it
      #5;
      for (int k = 0; k < 20; k++)
      begin
         #100 o_bclk = 1'b1;
         o_fsync = (k == 0);
         #100 o_bclk = 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** tb.sv ***
// tb: afsp_port against the codec model
// assumes 40 MHz i_clk and a 200 ns codec clock in slave mode
`timescale 1ns/1ps
`default_nettype none
module tb;
   import afsp_pkg::*;
   logic i_clk, i_reset, i_wb_we, i_wb_cyc, i_wb_stb, o_wb_ack, i_sdin;
   logic o_bclk, o_bclk_oe, o_fsync, o_fsync_oe, o_sdout, c_clk, c_fs;
   logic go, c_long;
   logic [3:0] i_wb_adr, i_wb_sel;
   logic [31:0] i_wb_dat, o_wb_dat, q;
   logic [15:0] c_tx, c_rx;
   logic [7:0] c_cnt;
   int miscompares = 0;
   int total_checks = 0;
   realtime t0, t1;
   // pin level comes from the side whose enable is high
   wire logic i_bclk = o_bclk_oe ? o_bclk : c_clk;
   wire logic i_fsync = o_fsync_oe ? o_fsync : c_fs;
   afsp_port DUT (.*);
   afsp_codec_model codec (.i_bclk(i_bclk), .i_fsync(i_fsync),
      .i_sdout(o_sdout), .i_long(c_long), .i_go(go), .i_tx(c_tx),
      .o_bclk(c_clk), .o_fsync(c_fs), .o_sdin(i_sdin), .o_rx(c_rx),
      .o_count(c_cnt));
   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic cycle, held until ack is seen at a rising edge
   task automatic wb(input logic [3:0] a, input logic w, logic [31:0] d);
      int n = 0;
      @(posedge i_clk);
      i_wb_adr <= a;
      i_wb_we <= w;
      i_wb_dat <= d;
      {i_wb_cyc, i_wb_stb} <= 2'b11;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (o_wb_ack !== 1'b1 && n < 20);
      q = o_wb_dat;
      {i_wb_cyc, i_wb_stb} <= 2'b00;
      chk("ack", 32'h1, {31'h0, n < 20});
   endtask
   task automatic wait_frame();
      logic [7:0] c0 = c_cnt;
      int n = 0;
      while (c_cnt === c0 && n < 12000)
      begin
         @(posedge i_clk);
         n++;
      end
      chk("frame", 32'h1, {31'h0, n < 12000});
   endtask
   // one sample each way, then status and read side effects
   task automatic xfer(input logic [15:0] d, e, input logic slv);
      c_tx <= e;
      if (!slv)
         wait_frame();
      wb(AFSP_REG_TXDATA, 1'b1, {16'h0, d});
      go <= slv;
      wait_frame();
      go <= 1'b0;
      chk("codec rx", {16'h0, d}, {16'h0, c_rx});
      repeat (8) @(posedge i_clk);
      wb(AFSP_REG_STATUS, 1'b0, 32'h0);
      chk("status", 32'h3, q);
      wb(AFSP_REG_RXDATA, 1'b0, 32'h0);
      chk("rxdata", {16'h0, e}, q);
      wb(AFSP_REG_STATUS, 1'b0, 32'h0);
      chk("status", 32'h2, q);
   endtask
   task automatic t_reset();
      wb(AFSP_REG_CTRL, 1'b0, 32'h0);
      chk("ctrl", 32'h130, q);
      chk("oe", 32'h3, {30'h0, o_fsync_oe, o_bclk_oe});
      wb(AFSP_REG_STATUS, 1'b0, 32'h0);
      chk("status", 32'h2, q);
      wb(4'h2, 1'b1, 32'hffff);
      wb(4'h2, 1'b0, 32'h0);
      chk("unmapped", 32'h0, q);
      xfer(16'ha5c3, 16'h3c5a, 1'b0);
      $display("reset and short master done");
   endtask
   // frame period in clocks for every bit clock code
   task automatic t_rates();
      int khz;
      for (int r = 0; r < 5; r++)
      begin
         khz = 256 << r;
         wb(AFSP_REG_CTRL, 1'b1, 32'h100 | (r << 4));
         @(posedge o_fsync);
         t0 = $realtime;
         @(posedge o_fsync);
         chk("period", 2 * (20000 / khz) * (r == 4 ? 256 : khz / 8),
            int'(($realtime - t0) / 25.0));
      end
      $display("rates done");
   endtask
   task automatic t_long();
      wb(AFSP_REG_CTRL, 1'b1, 32'h103);
      c_long <= 1'b1;
      @(posedge o_fsync);
      t0 = $realtime;
      @(negedge o_fsync);
      t1 = $realtime;
      @(posedge o_fsync);
      chk("high", 32'd2496, int'((t1 - t0) / 25.0));
      chk("low", 32'd2496, int'(($realtime - t1) / 25.0));
      chk("long oe", 32'h3, {30'h0, o_fsync_oe, o_bclk_oe});
      xfer(16'h8001, 16'h7ffe, 1'b0);
      $display("long done");
   endtask
   task automatic t_slave();
      wb(AFSP_REG_CTRL, 1'b1, 32'h131);
      c_long <= 1'b0;
      repeat (2) @(posedge i_clk);
      chk("slave oe", 32'h0, {30'h0, o_fsync_oe, o_bclk_oe});
      xfer(16'hc001, 16'h0ff3, 1'b1);
      // enable off: the codec still clocks a frame, the port stays idle
      wb(AFSP_REG_CTRL, 1'b1, 32'h031);
      wb(AFSP_REG_TXDATA, 1'b1, 32'h1234);
      go <= 1'b1;
      wait_frame();
      go <= 1'b0;
      chk("idle out", 32'h0, {16'h0, c_rx});
      repeat (8) @(posedge i_clk);
      wb(AFSP_REG_STATUS, 1'b0, 32'h0);
      chk("disabled", 32'h0, q);
      $display("slave done");
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      i_reset = 1'b1;
      {i_wb_we, i_wb_cyc, i_wb_stb, go, c_long} = '0;
      {i_wb_adr, i_wb_sel, i_wb_dat, c_tx} = {4'h0, 4'hf, 48'h0};
      repeat (12) @(posedge i_clk);
      i_reset <= 1'b0;
      t_reset();
      t_rates();
      t_long();
      t_slave();
      test_done();
   end
   // hang guard, about 100k clocks
   initial
   begin
      #2500000;
      miscompares++;
      test_done();
   end
endmodule
`default_nettype wire
